// File: src/ucfg_cfg.svh
// Constants of the endpoint and DMA configuration block: command codes, field
// positions, reset values and the register offsets of the controller end.
// Assumes it is included by its bare name from the package and both ends.
`ifndef UCFG_CFG_SVH
`define UCFG_CFG_SVH
// Command codes on the link.
`define UCFG_CMD_DMA       8'hFB
`define UCFG_CMD_IRQ       8'hF4
`define UCFG_CMD_EPCFG_HI  4'hB
// Fields of the DMA set-up byte.
`define UCFG_BURST_HI      1
`define UCFG_BURST_LO      0
`define UCFG_EN_BIT        2
`define UCFG_DIR_BIT       3
`define UCFG_RELOAD_BIT    4
`define UCFG_PINMODE_BIT   5
`define UCFG_EP4EN_BIT     6
`define UCFG_EP5EN_BIT     7
// Fields of an endpoint configuration byte.
`define UCFG_EPC_EN_BIT    0
`define UCFG_EPC_TYPE_HI   2
`define UCFG_EPC_TYPE_LO   1
`define UCFG_EPC_MPS_HI    6
`define UCFG_EPC_MPS_LO    3
// Reset values.
`define UCFG_SETUP_RST     8'h00
`define UCFG_EPSEL_RST     4'h0
`define UCFG_EPCFG_RST     7'h00
// Endpoint indexes with their own enable bits.
`define UCFG_EP_FOUR       4'h4
`define UCFG_EP_FIVE       4'h5
// Controller register offsets and response codes.
`define UCFG_OFS_OP        4'h0
`define UCFG_OFS_STAT      4'h4
`define UCFG_RESP_OKAY     2'h0
`define UCFG_RESP_SLVERR   2'h2
`endif

// File: src/ucfg_pkg.sv
// Types shared by the two ends of the configuration link.
// Assumes the constants header sits beside it.
`include "ucfg_cfg.svh"
package ucfg_pkg;
	// Kind of one link transfer.
	typedef enum logic [1:0] {UCFG_K_CMD, UCFG_K_WR, UCFG_K_RD, UCFG_K_NONE} ucfg_kind_t;
	// DMA sequencer states.
	typedef enum logic [1:0] {UCFG_D_IDLE, UCFG_D_BURST, UCFG_D_RELOAD} ucfg_dma_st_t;
	// Whole state of the device end.
	typedef struct packed {
		logic              ack;
		logic [7:0]        rbyte;
		logic [7:0]        cmd;
		logic [1:0]        idx;
		logic [7:0]        setup;
		logic [3:0]        ep_sel;
		logic [3:0]        ep_out;
		logic [15:0][6:0]  ep_cfg;
		logic              eot_flag;
		ucfg_dma_st_t      st;
		logic [3:0]        cnt;
		logic              req;
		logic              strobe;
		logic              intr;
	} ucfg_dev_st_t;
	// Whole state of the controller end.
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              arready;
		logic              aw_got;
		logic [3:0]        awaddr;
		logic              w_got;
		logic [31:0]       wdata;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              req;
		ucfg_kind_t        kind;
		logic [7:0]        wbyte;
		logic [7:0]        last;
		logic              done;
	} ucfg_host_st_t;
endpackage

// File: src/ucfg_if.sv
// Byte-wide command link between the controller end and the device end.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/10ps
interface ucfg_if;
	logic                 req;
	ucfg_pkg::ucfg_kind_t kind;
	logic [7:0]           wbyte;
	logic                 ack;
	logic [7:0]           rbyte;
	modport dev  (input req, input kind, input wbyte, output ack, output rbyte);
	modport host (output req, output kind, output wbyte, input ack, input rbyte);
endinterface

// File: src/ucfg_dev.sv
// Device end: command decoder for DMA set-up and endpoint configuration,
// DMA burst sequencer toward an external agent, and the interrupt pin.
// Assumes the link, the agent pins and the event inputs are synchronous to aclk.
`timescale 1ns/10ps
`include "ucfg_cfg.svh"
module ucfg_dev #(
	parameter logic [3:0] DEFAULT_DMA_EP = 4'h4
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	ucfg_if.dev               link,
	input  wire logic         enhanced_mode,
	input  wire logic         sof_only_mode,
	input  wire logic         sof_seen,
	input  wire logic [7:0]   irq_byte1,
	input  wire logic [15:0]  ep_irq,
	input  wire logic         buf_ready,
	input  wire logic         dma_ack,
	input  wire logic         end_of_transfer_in_n,
	output logic              dma_req,
	output logic              dma_strobe,
	output logic              dma_dir,
	output logic [3:0]        dma_ep,
	output logic              dma_enabled,
	output logic              intr,
	output logic [15:0][6:0]  ep_cfg
);

	ucfg_pkg::ucfg_dev_st_t q;
	ucfg_pkg::ucfg_dev_st_t d;

	// Number of data cycles in one request for a burst code.
	function automatic logic [4:0] burst_len(input logic [1:0] code);
		logic [4:0] n;
		n = 5'h01;
		unique case (code)
			2'h0: n = 5'h01;
			2'h1: n = 5'h04;
			2'h2: n = 5'h08;
			2'h3: n = 5'h10;
		endcase
		return n;
	endfunction

	// Next byte position within a command, saturating.
	function automatic logic [1:0] bump(input logic [1:0] i);
		return (i == 2'h3) ? i : i + 2'h1;
	endfunction

	logic        eot;
	logic        is_epcfg;
	logic [15:0] ep_gated;
	logic        any_irq;

	// Decodes for the current command and the pin events.
	always_comb begin
		eot      = !end_of_transfer_in_n;
		is_epcfg = (q.cmd[7:4] == `UCFG_CMD_EPCFG_HI);
	end

	// Next-state logic of the whole device end.
	always_comb begin
		d        = q;
		d.ack    = 1'b0;
		d.strobe = 1'b0;

		// One link transfer is taken per request; ack marks the answer.
		if (link.req && !q.ack) begin
			d.ack   = 1'b1;
			d.rbyte = 8'h00;
			unique case (link.kind)
				ucfg_pkg::UCFG_K_CMD: begin
					d.cmd = link.wbyte;
					d.idx = 2'h0;
				end
				ucfg_pkg::UCFG_K_WR: begin
					if (q.cmd == `UCFG_CMD_DMA) begin
						if (q.idx == 2'h0) begin
							d.setup = link.wbyte;
						end else if (q.idx == 2'h1 && enhanced_mode) begin
							d.ep_sel = link.wbyte[3:0];
						end
					end else if (is_epcfg && enhanced_mode && q.idx == 2'h0) begin
						d.ep_cfg[q.cmd[3:0]] = link.wbyte[6:0];
					end
					d.idx = bump(q.idx);
				end
				ucfg_pkg::UCFG_K_RD: begin
					if (q.cmd == `UCFG_CMD_DMA) begin
						if (q.idx == 2'h0) begin
							d.rbyte = q.setup;
						end else if (q.idx == 2'h1 && enhanced_mode) begin
							d.rbyte = {4'h0, q.ep_sel};
						end
					end else if (q.cmd == `UCFG_CMD_IRQ) begin
						if (q.idx == 2'h0) begin
							d.rbyte = irq_byte1;
						end else if (q.idx == 2'h1) begin
							d.rbyte    = {7'h00, q.eot_flag};
							d.eot_flag = 1'b0;
						end
					end
					d.idx = bump(q.idx);
				end
				ucfg_pkg::UCFG_K_NONE: begin
					d.idx = q.idx;
				end
			endcase
		end

		// Burst sequencer: one request, a fixed count of acknowledged cycles.
		unique case (q.st)
			ucfg_pkg::UCFG_D_IDLE: begin
				if (q.setup[`UCFG_EN_BIT] && buf_ready) begin
					d.st  = ucfg_pkg::UCFG_D_BURST;
					d.req = 1'b1;
					d.cnt = 4'h0;
				end
			end
			ucfg_pkg::UCFG_D_BURST: begin
				if (!q.setup[`UCFG_EN_BIT]) begin
					d.req = 1'b0;
					d.st  = ucfg_pkg::UCFG_D_IDLE;
				end else if (dma_ack) begin
					d.strobe = 1'b1;
					if ({1'b0, q.cnt} == burst_len(q.setup[`UCFG_BURST_HI:`UCFG_BURST_LO]) - 5'h01) begin
						d.req = 1'b0;
						d.st  = ucfg_pkg::UCFG_D_IDLE;
					end else begin
						d.cnt = q.cnt + 4'h1;
					end
				end
			end
			ucfg_pkg::UCFG_D_RELOAD: begin
				d.setup[`UCFG_EN_BIT] = 1'b1;
				d.st                  = ucfg_pkg::UCFG_D_IDLE;
			end
			default: begin
				d.st = ucfg_pkg::UCFG_D_IDLE;
			end
		endcase

		// End of transfer wins over a software write and over a flag read.
		if (eot && q.setup[`UCFG_EN_BIT]) begin
			d.setup[`UCFG_EN_BIT] = 1'b0;
			d.eot_flag            = 1'b1;
			d.req                 = 1'b0;
			d.strobe              = 1'b0;
			d.st = q.setup[`UCFG_RELOAD_BIT] ? ucfg_pkg::UCFG_D_RELOAD
			                                 : ucfg_pkg::UCFG_D_IDLE;
		end

		// Interrupt pin, registered.
		if (sof_only_mode) begin
			d.intr = sof_seen;
		end else begin
			d.intr = any_irq || (q.setup[`UCFG_PINMODE_BIT] && sof_seen);
		end

		// Endpoint shown to the agent; registered so that the pin comes from a flop.
		d.ep_out = enhanced_mode ? d.ep_sel : DEFAULT_DMA_EP;
	end

	// Endpoint interrupt gating for indexes four and five.
	always_comb begin
		ep_gated = ep_irq;
		if (enhanced_mode) begin
			if (q.ep_sel == `UCFG_EP_FOUR) begin
				ep_gated[`UCFG_EP_FOUR] = 1'b0;
			end
			if (q.ep_sel == `UCFG_EP_FIVE) begin
				ep_gated[`UCFG_EP_FIVE] = 1'b0;
			end
		end else begin
			ep_gated[`UCFG_EP_FOUR] = ep_irq[`UCFG_EP_FOUR] && q.setup[`UCFG_EP4EN_BIT];
			ep_gated[`UCFG_EP_FIVE] = ep_irq[`UCFG_EP_FIVE] && q.setup[`UCFG_EP5EN_BIT];
		end
		any_irq = (|irq_byte1) || (|ep_gated) || q.eot_flag;
	end

	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q          <= '0;
			q.setup    <= `UCFG_SETUP_RST;
			q.ep_sel   <= `UCFG_EPSEL_RST;
			q.ep_cfg   <= {16{`UCFG_EPCFG_RST}};
			q.ep_out   <= DEFAULT_DMA_EP;
			q.st       <= ucfg_pkg::UCFG_D_IDLE;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register.
	assign link.ack    = q.ack;
	assign link.rbyte  = q.rbyte;
	assign dma_req     = q.req;
	assign dma_strobe  = q.strobe;
	assign dma_dir     = q.setup[`UCFG_DIR_BIT];
	assign dma_ep      = q.ep_out;
	assign dma_enabled = q.setup[`UCFG_EN_BIT];
	assign intr        = q.intr;
	assign ep_cfg      = q.ep_cfg;

endmodule // ucfg_dev

// File: src/ucfg_host.sv
// Controller end: an AXI4-Lite slave whose writes launch link transfers
// and whose status word shows progress and the last byte read.
// Assumes the AXI master and the link share aclk and aresetn.
`timescale 1ns/10ps
`include "ucfg_cfg.svh"
module ucfg_host (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	ucfg_if.host              link,
	input  wire logic [31:0]  s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [31:0]  s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready
);

	ucfg_pkg::ucfg_host_st_t q;
	ucfg_pkg::ucfg_host_st_t d;

	// Next-state logic: bus slave and link requester.
	always_comb begin
		d = q;
		// Link answer ends the request and keeps the byte.
		if (q.req && link.ack) begin
			d.req  = 1'b0;
			d.last = link.rbyte;
			d.done = 1'b1;
		end
		// Write address and data are taken in either order.
		if (s_axi_awvalid && q.awready) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr[3:0];
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		// Both halves present: perform the write and answer.
		if (d.aw_got && d.w_got && !q.bvalid) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = `UCFG_RESP_OKAY;
			if (d.awaddr == `UCFG_OFS_OP) begin
				// A new transfer while one is pending is ignored.
				if (!q.req && s_axi_wstrb[0] && d.wdata[9:8] != 2'h3) begin
					d.req   = 1'b1;
					d.wbyte = d.wdata[7:0];
					d.done  = 1'b0;
					unique case (d.wdata[9:8])
						2'h0: d.kind = ucfg_pkg::UCFG_K_CMD;
						2'h1: d.kind = ucfg_pkg::UCFG_K_WR;
						2'h2: d.kind = ucfg_pkg::UCFG_K_RD;
						default: d.kind = ucfg_pkg::UCFG_K_NONE;
					endcase
				end
			end else if (d.awaddr != `UCFG_OFS_STAT) begin
				d.bresp = `UCFG_RESP_SLVERR;
			end
		end
		// Reads answer one cycle after the address is taken.
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp  = `UCFG_RESP_OKAY;
			d.rdata  = 32'h0000_0000;
			unique case (s_axi_araddr[3:0])
				`UCFG_OFS_OP:   d.rdata = {22'h000000, q.kind, q.wbyte};
				`UCFG_OFS_STAT: d.rdata = {16'h0000, q.last, 6'h00, q.done, q.req};
				default:        d.rresp = `UCFG_RESP_SLVERR;
			endcase
		end
		d.awready = !d.aw_got && !d.bvalid;
		d.wready  = !d.w_got && !d.bvalid;
		d.arready = !d.rvalid;
	end

	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q      <= '0;
			q.kind <= ucfg_pkg::UCFG_K_NONE;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register.
	assign s_axi_awready = q.awready;
	assign s_axi_wready  = q.wready;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign link.req      = q.req;
	assign link.kind     = q.kind;
	assign link.wbyte    = q.wbyte;

endmodule // ucfg_host

// File: testbench/ucfg_checker.sv
// Assertions on the link and on the DMA and interrupt pins of the device end.
// Assumes one clock and an active-low synchronous reset.
`timescale 1ns/10ps
module ucfg_checker (
	input logic       aclk,
	input logic       aresetn,
	input logic       req,
	input logic       ack,
	input logic [7:0] rbyte,
	input logic       enhanced_mode,
	input logic       sof_only_mode,
	input logic       sof_seen,
	input logic [7:0] irq_byte1,
	input logic       dma_ack,
	input logic       end_of_transfer_in_n,
	input logic       dma_req,
	input logic       dma_strobe,
	input logic       dma_enabled,
	input logic [3:0] dma_ep,
	input logic       intr
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// A link byte is taken while it is pending and unanswered.
	sequence link_take;
		req && !ack;
	endsequence
	// A data cycle is accepted while request and acknowledge meet.
	sequence beat;
		dma_req && dma_ack;
	endsequence
	link_answer_a: assert property (link_take |=> ack)
		else $error("link byte not answered in one cycle");
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("link answer longer than one cycle");
	rbyte_hold_a: assert property (!ack |-> $stable(rbyte))
		else $error("read byte moved without an answer");
	beat_strobe_a: assert property (beat |=> dma_strobe)
		else $error("data cycle without strobe");
	strobe_cause_a: assert property (!(dma_req && dma_ack) |=> !dma_strobe)
		else $error("strobe without data cycle");
	idle_off_a: assert property (!dma_enabled |=> !dma_req)
		else $error("request while disabled");
	eot_stop_a: assert property (dma_enabled && !end_of_transfer_in_n |=> !dma_enabled && !dma_req)
		else $error("end of transfer did not stop the engine");
	sof_only_a: assert property (sof_only_mode |=> intr == $past(sof_seen))
		else $error("pin does not follow frame starts only");
	irq_any_a: assert property (!sof_only_mode && irq_byte1 != 8'h00 |=> intr)
		else $error("pin low with a source pending");
	dflt_ep_a: assert property (!enhanced_mode |=> dma_ep == 4'h4)
		else $error("wrong fixed endpoint in default mode");
endmodule // ucfg_checker

// File: testbench/ucfg_test.sv
// Self-checking bench: AXI4-Lite orders reach the device end over the link,
// and the agent and event pins are driven directly.
// Assumes package, interface, both ends and the checker are compiled first.
`timescale 1ns/10ps
`include "ucfg_cfg.svh"
module ucfg_test;
	logic             aclk = 1'h0, aresetn = 1'h0;
	logic [31:0]      s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0]       s_axi_wstrb = 4'hF;
	logic             s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic             s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]       s_axi_bresp, s_axi_rresp;
	logic [31:0]      s_axi_rdata;
	logic             enhanced_mode = 1'h0, sof_only_mode = 1'h0, sof_seen = 1'h0;
	logic [7:0]       irq_byte1 = 8'h00;
	logic [15:0]      ep_irq = 16'h0000;
	logic             buf_ready = 1'h0, dma_ack = 1'h0, end_of_transfer_in_n = 1'h1;
	logic             dma_req, dma_strobe, dma_dir, dma_enabled, intr;
	logic [3:0]       dma_ep;
	logic [15:0][6:0] ep_cfg;
	int               errors = 0, compares = 0, strobes = 0;
	// The link joins the two ends; the checker watches it.
	ucfg_if ucfg_if_inst ();
	ucfg_host ucfg_host_inst (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.link          (ucfg_if_inst.host),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready)
	);
	ucfg_dev ucfg_dev_inst (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.link                 (ucfg_if_inst.dev),
		.enhanced_mode        (enhanced_mode),
		.sof_only_mode        (sof_only_mode),
		.sof_seen             (sof_seen),
		.irq_byte1            (irq_byte1),
		.ep_irq               (ep_irq),
		.buf_ready            (buf_ready),
		.dma_ack              (dma_ack),
		.end_of_transfer_in_n (end_of_transfer_in_n),
		.dma_req              (dma_req),
		.dma_strobe           (dma_strobe),
		.dma_dir              (dma_dir),
		.dma_ep               (dma_ep),
		.dma_enabled          (dma_enabled),
		.intr                 (intr),
		.ep_cfg               (ep_cfg)
	);
	ucfg_checker ucfg_checker_inst (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.req                  (ucfg_if_inst.req),
		.ack                  (ucfg_if_inst.ack),
		.rbyte                (ucfg_if_inst.rbyte),
		.enhanced_mode        (enhanced_mode),
		.sof_only_mode        (sof_only_mode),
		.sof_seen             (sof_seen),
		.irq_byte1            (irq_byte1),
		.dma_ack              (dma_ack),
		.end_of_transfer_in_n (end_of_transfer_in_n),
		.dma_req              (dma_req),
		.dma_strobe           (dma_strobe),
		.dma_enabled          (dma_enabled),
		.dma_ep               (dma_ep),
		.intr                 (intr)
	);
	// Clock of 4 ns period.
	always #2 aclk = ~aclk;
	// Counts the data cycles that the device end reports.
	always @(posedge aclk) begin
		if (dma_strobe === 1'h1) strobes++;
	end
	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic test_done;
		$display("%0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// A wait that ran out counts as a mismatch.
	task automatic hang;
		errors++;
		test_done;
	endtask
	// Writes one word; address and data are released as each is taken.
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] e);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 30; n++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1) break;
		end
		s_axi_bready <= 1'h0;
		e = s_axi_bresp;
		if (n == 30) hang;
	endtask
	// Reads one word with its response.
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] e);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 30; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1) break;
		end
		s_axi_rready <= 1'h0;
		d = s_axi_rdata;
		e = s_axi_rresp;
		if (n == 30) hang;
	endtask
	// Launches one link transfer and polls status until it has finished.
	task automatic lk(input ucfg_pkg::ucfg_kind_t k, input logic [7:0] b, output logic [7:0] r);
		logic [31:0] d;
		logic [1:0]  e;
		int          n;
		wr(32'h0, {22'h0, k, b}, e);
		chk(e, `UCFG_RESP_OKAY);
		for (n = 0; n < 20; n++) begin
			rd(32'h4, d, e);
			if (d[0] === 1'h0) break;
		end
		if (n == 20) hang;
		r = d[15:8];
	endtask
	// Writes one data byte on the link.
	task automatic wb(input logic [7:0] b);
		logic [7:0] r;
		lk(ucfg_pkg::UCFG_K_WR, b, r);
	endtask
	// Reads one data byte from the link.
	task automatic rb(output logic [7:0] r);
		lk(ucfg_pkg::UCFG_K_RD, 8'h00, r);
	endtask
	// Sends a command followed by its first data byte.
	task automatic cw(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		lk(ucfg_pkg::UCFG_K_CMD, c, r);
		wb(b);
	endtask
	// Waits, within a bound, for the DMA request to show a level.
	task automatic wreq(input logic v);
		int n;
		for (n = 0; n < 40 && dma_req !== v; n++) @(posedge aclk);
		if (n == 40) hang;
	endtask
	// Gives one frame-start pulse and lets the pin answer.
	task automatic sofp;
		@(posedge aclk);
		sof_seen <= 1'h1;
		@(posedge aclk);
		sof_seen <= 1'h0;
		@(posedge aclk);
	endtask
	// Main sequence: reset, then one block of calls per area of behaviour.
	initial begin
		logic [31:0] d;
		logic [1:0]  e;
		logic [7:0]  r;
		int          i;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		chk({dma_req, dma_enabled, dma_dir, intr}, 4'h0);
		rd(32'h4, d, e);
		chk({e, d}, 34'h0);
		wr(32'h8, 32'h0, e);
		chk(e, `UCFG_RESP_SLVERR);
		rd(32'hC, d, e);
		chk({e, d}, {`UCFG_RESP_SLVERR, 32'h0});
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			cw(`UCFG_CMD_DMA, {4'h0, i[0], 1'h1, i[1:0]});
			chk(dma_dir, i[0]);
			strobes = 0;
			buf_ready <= 1'h1;
			dma_ack <= 1'h1;
			wreq(1'h1);
			buf_ready <= 1'h0;
			wreq(1'h0);
			repeat (3) @(posedge aclk);
			dma_ack <= 1'h0;
			chk(strobes, (i == 0) ? 1 : 2 << i);
		end
		cw(`UCFG_CMD_DMA, 8'h03);
		buf_ready <= 1'h1;
		dma_ack <= 1'h1;
		strobes = 0;
		repeat (20) @(posedge aclk);
		chk({strobes, dma_req}, 33'h000000000);
		buf_ready <= 1'h0;
		dma_ack <= 1'h0;
		for (i = 0; i < 2; i++) begin
			cw(`UCFG_CMD_DMA, {3'h0, i[0], 4'h4});
			end_of_transfer_in_n <= 1'h0;
			@(posedge aclk);
			end_of_transfer_in_n <= 1'h1;
			repeat (3) @(posedge aclk);
			chk({dma_enabled, intr}, {i[0], 1'h1});
			cw(`UCFG_CMD_IRQ, 8'h00);
			rb(r);
			chk(r, 8'h01);
			cw(`UCFG_CMD_IRQ, 8'h00);
			rb(r);
			chk({r, intr}, 9'h000);
		end
		$display("test dma done");
		for (i = 0; i < 2; i++) begin
			ep_irq <= 16'h0010 << i;
			cw(`UCFG_CMD_DMA, 8'h00);
			chk(intr, 1'h0);
			cw(`UCFG_CMD_DMA, 8'h40 << i);
			chk(intr, 1'h1);
			ep_irq <= 16'h0000;
			cw(`UCFG_CMD_DMA, {2'h0, i[0], 5'h00});
			sofp;
			chk(intr, i[0]);
		end
		irq_byte1 <= 8'h80;
		repeat (2) @(posedge aclk);
		chk(intr, 1'h1);
		sof_only_mode <= 1'h1;
		repeat (2) @(posedge aclk);
		chk(intr, 1'h0);
		sofp;
		chk(intr, 1'h1);
		sof_only_mode <= 1'h0;
		irq_byte1 <= 8'h00;
		$display("test interrupt pin done");
		enhanced_mode <= 1'h1;
		ep_irq <= 16'h0010;
		for (i = 0; i < 16; i++) begin
			cw(`UCFG_CMD_DMA, 8'h00);
			wb(i[7:0]);
			chk({dma_ep, intr}, {i[3:0], i != 4});
		end
		cw(`UCFG_CMD_DMA, 8'h00);
		rb(r);
		chk(r, 8'h0F);
		for (i = 0; i < 16; i++) begin
			cw({`UCFG_CMD_EPCFG_HI, i[3:0]}, {1'h0, ~i[3:0], i[2:0]});
		end
		for (i = 0; i < 16; i++) begin
			chk(ep_cfg[i], {~i[3:0], i[2:0]});
		end
		enhanced_mode <= 1'h0;
		cw({`UCFG_CMD_EPCFG_HI, 4'h0}, 8'h00);
		cw(`UCFG_CMD_DMA, 8'h00);
		rb(r);
		chk({r, dma_ep, ep_cfg[0]}, {8'h00, `UCFG_EP_FOUR, 7'h78});
		$display("test endpoint setup done");
		test_done;
	end
endmodule // ucfg_test
